// ===== pkg/vimgr_arb_if.sv
`timescale 1ns/10ps
interface vimgr_arb_if;
    import vimgr_pkg::*;

    logic [NUM_CHAN-1:0] pend;
    logic [CHAN_W-1:0]   rank [NUM_CHAN];
    logic                win_valid;
    logic [CHAN_W-1:0]   win_chan;

    modport master (output pend, output rank, input win_valid, input win_chan);
    modport arbiter (input pend, input rank, output win_valid, output win_chan);
endinterface

// ===== pkg/vimgr_pkg.sv
package vimgr_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_CHAN   = 96;
    localparam int CHAN_W     = 7;
    localparam int VEC_W      = 32;
    localparam int RAM_DEPTH  = 96;
    localparam int LAST_USABLE = 94;

    // ==========================================================
    // Vector table layout
    localparam logic [CHAN_W-1:0] PHANTOM_ENTRY = 7'h00;
    localparam logic [CHAN_W-1:0] ENTRY_OFFSET  = 7'h01;
    localparam logic [VEC_W-1:0]  VEC_RESET     = 32'h00000000;
    localparam logic [CHAN_W-1:0] INDEX_NONE    = 7'h00;

    // ==========================================================
    // Priority rank programming through the table write port
    localparam logic [CHAN_W-1:0] PRIO_ADDR     = 7'h60;
    localparam int                PRIO_CHAN_LSB = 0;
    localparam int                PRIO_RANK_LSB = 8;

    // ==========================================================
    // Default channel assignment
    localparam int CH_ERR_HIGH    = 0;
    localparam int CH_TICK_CMP0   = 2;
    localparam int CH_TICK_CMP1   = 3;
    localparam int CH_TICK_CMP2   = 4;
    localparam int CH_TICK_CMP3   = 5;
    localparam int CH_TICK_OVF0   = 6;
    localparam int CH_TICK_OVF1   = 7;
    localparam int CH_GIO_A       = 9;
    localparam int CH_TCOP_L0     = 10;
    localparam int CH_TTU_L0      = 11;
    localparam int CH_MBSP1_L0    = 12;
    localparam int CH_LIN_L0      = 13;
    localparam int CH_CONV_EVT    = 14;
    localparam int CH_CONV_SW1    = 15;
    localparam int CH_CAN1_L0     = 16;
    localparam int CH_SP2_L0      = 17;
    localparam int CH_ERR_LOW     = 20;
    localparam int CH_SW_IRQ      = 21;
    localparam int CH_PERF_MON    = 22;
    localparam int CH_GIO_B       = 23;
    localparam int CH_TCOP_L1     = 24;
    localparam int CH_TTU_L1      = 25;
    localparam int CH_MBSP1_L1    = 26;
    localparam int CH_LIN_L1      = 27;
    localparam int CH_CONV_SW2    = 28;
    localparam int CH_CAN1_L1     = 29;
    localparam int CH_SP2_L1      = 30;
    localparam int CH_CONV_MAG    = 31;
    localparam int CH_CAN2_L0     = 35;
    localparam int CH_SP3_L0      = 37;
    localparam int CH_SP3_L1      = 38;
    localparam int CH_CAN2_L1     = 42;
    localparam int CH_FLASH_DONE  = 61;
    localparam int CH_ANGLE_HIGH  = 80;
    localparam int CH_CLK_CMP     = 82;
    localparam int CH_QUAD_ENC    = 84;
    localparam int CH_MBIST_DONE  = 85;
    localparam int CH_ANGLE_LOW   = 88;

    localparam int ASSIGNED [38] = '{
        CH_ERR_HIGH, CH_TICK_CMP0, CH_TICK_CMP1, CH_TICK_CMP2, CH_TICK_CMP3,
        CH_TICK_OVF0, CH_TICK_OVF1, CH_GIO_A, CH_TCOP_L0, CH_TTU_L0,
        CH_MBSP1_L0, CH_LIN_L0, CH_CONV_EVT, CH_CONV_SW1, CH_CAN1_L0,
        CH_SP2_L0, CH_ERR_LOW, CH_SW_IRQ, CH_PERF_MON, CH_GIO_B,
        CH_TCOP_L1, CH_TTU_L1, CH_MBSP1_L1, CH_LIN_L1, CH_CONV_SW2,
        CH_CAN1_L1, CH_SP2_L1, CH_CONV_MAG, CH_CAN2_L0, CH_SP3_L0,
        CH_SP3_L1, CH_CAN2_L1, CH_FLASH_DONE, CH_ANGLE_HIGH, CH_CLK_CMP,
        CH_QUAD_ENC, CH_MBIST_DONE, CH_ANGLE_LOW
    };

    function automatic logic [NUM_CHAN-1:0] used_mask();
        logic [NUM_CHAN-1:0] m;
        m = '0;
        foreach (ASSIGNED[i])
            m[ASSIGNED[i]] = 1'b1;
        return m;
    endfunction

    localparam logic [NUM_CHAN-1:0] USED_MASK = used_mask();

endpackage

// ===== src/vimgr_arbiter.sv
`timescale 1ns/10ps
module vimgr_arbiter
    import vimgr_pkg::*;
(
    vimgr_arb_if.arbiter arb
);

    logic [2*CHAN_W-1:0] best_key;
    logic [2*CHAN_W-1:0] cand_key;

    // ==========================================================
    // Lowest rank wins; channel number breaks ties
    always_comb
    begin
        best_key      = '1;
        cand_key      = '1;
        arb.win_valid = 1'b0;
        arb.win_chan  = '0;
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            cand_key = {arb.rank[i], CHAN_W'(i)};
            if (arb.pend[i] && (cand_key < best_key))
            begin
                best_key      = cand_key;
                arb.win_valid = 1'b1;
                arb.win_chan  = CHAN_W'(i);
            end
        end
    end

endmodule

// ===== src/vimgr_top.sv
`timescale 1ns/10ps
module vimgr_top
    import vimgr_pkg::*;
(
    // Clock and reset
    input  wire logic                MCLK,
    input  wire logic                RST_N,
    // Peripheral requests and enables
    input  wire logic [NUM_CHAN-1:0] REQ_IN,
    input  wire logic [NUM_CHAN-1:0] CHAN_ENABLE,
    // Vector table write port
    input  wire logic                TBL_WR_EN,
    input  wire logic [CHAN_W-1:0]   TBL_WR_ADDR,
    input  wire logic [VEC_W-1:0]    TBL_WR_DATA,
    // Processor vector port
    output logic                     VEC_PORT_REQ,
    output logic [VEC_W-1:0]         VEC_PORT_ADDR,
    // Software dispatch
    output logic [CHAN_W-1:0]        IRQ_INDEX,
    output logic [VEC_W-1:0]         IRQ_VECTOR,
    // Table parity
    output logic                     PARITY_ERR
);

    // ==========================================================
    // Vector table, one parity bit per entry
    logic [VEC_W:0]      tbl_mem [RAM_DEPTH];
    vimgr_arb_if         arb_if ();
    logic                win_valid_r;
    logic [CHAN_W-1:0]   win_chan_r;
    logic [CHAN_W-1:0]   fetch_addr;
    logic [VEC_W:0]      fetch_word;
    logic                fetch_bad;
    logic                rank_wr;

    // Reserved channels and the unusable top slot are dropped here
    assign arb_if.pend = REQ_IN & CHAN_ENABLE & USED_MASK;

    vimgr_arbiter u_arb (
        .arb (arb_if.arbiter)
    );

    // ==========================================================
    // Per-channel priority ranks
    // Reset rank equals channel number, so lowest channel wins by default
    assign rank_wr = TBL_WR_EN && (TBL_WR_ADDR == PRIO_ADDR);

    for (genvar g = 0; g < NUM_CHAN; g++)
    begin : g_rank
        logic [CHAN_W-1:0] rank_r;

        always_ff @(posedge MCLK)
        begin
            if (!RST_N)
            begin
                rank_r <= CHAN_W'(g);
            end
            else if (rank_wr && (TBL_WR_DATA[PRIO_CHAN_LSB +: CHAN_W] == CHAN_W'(g)))
            begin
                rank_r <= TBL_WR_DATA[PRIO_RANK_LSB +: CHAN_W];
            end
        end

        assign arb_if.rank[g] = rank_r;
    end

    // ==========================================================
    // Stage 1: capture winner
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            win_valid_r <= 1'b0;
            win_chan_r  <= '0;
        end
        else
        begin
            win_valid_r <= arb_if.win_valid;
            win_chan_r  <= arb_if.win_chan;
        end
    end

    // ==========================================================
    // Table write and fetch
    always_ff @(posedge MCLK)
    begin
        if (TBL_WR_EN && (int'(TBL_WR_ADDR) < RAM_DEPTH))
        begin
            tbl_mem[TBL_WR_ADDR] <= {^TBL_WR_DATA, TBL_WR_DATA};
        end
    end

    // Phantom entry served when no winner was captured in stage 1
    assign fetch_addr = win_valid_r ? (win_chan_r + ENTRY_OFFSET) : PHANTOM_ENTRY;
    assign fetch_word = tbl_mem[fetch_addr];
    assign fetch_bad  = ^fetch_word;

    // ==========================================================
    // Stage 2: outputs
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            VEC_PORT_REQ  <= 1'b0;
            VEC_PORT_ADDR <= VEC_RESET;
            IRQ_INDEX     <= INDEX_NONE;
            IRQ_VECTOR    <= VEC_RESET;
        end
        else
        begin
            VEC_PORT_REQ  <= win_valid_r;
            VEC_PORT_ADDR <= fetch_word[VEC_W-1:0];
            IRQ_INDEX     <= win_valid_r ? (win_chan_r + ENTRY_OFFSET) : INDEX_NONE;
            IRQ_VECTOR    <= fetch_word[VEC_W-1:0];
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            PARITY_ERR <= 1'b0;
        else
            PARITY_ERR <= win_valid_r && fetch_bad;
    end

endmodule

// ===== verification/vimgr_checker.sv
`timescale 1ns/10ps
module vimgr_checker
    import vimgr_pkg::*;
(
    // Watched ports
    input wire logic                MCLK,
    input wire logic                RST_N,
    input wire logic [NUM_CHAN-1:0] REQ_IN,
    input wire logic [NUM_CHAN-1:0] CHAN_ENABLE,
    input wire logic                TBL_WR_EN,
    input wire logic [CHAN_W-1:0]   TBL_WR_ADDR,
    input wire logic [VEC_W-1:0]    TBL_WR_DATA,
    input wire logic                VEC_PORT_REQ,
    input wire logic [VEC_W-1:0]    VEC_PORT_ADDR,
    input wire logic [CHAN_W-1:0]   IRQ_INDEX,
    input wire logic [VEC_W-1:0]    IRQ_VECTOR,
    input wire logic                PARITY_ERR
);
    logic [NUM_CHAN-1:0] act;
    logic [CHAN_W-1:0]   low;
    logic [CHAN_W-1:0]   best_rank;
    logic [CHAN_W-1:0]   rank_m [NUM_CHAN];
    logic [VEC_W-1:0]    shadow [RAM_DEPTH];
    assign act = REQ_IN & CHAN_ENABLE & USED_MASK;
    // Model of table contents and ranks, kept from the write port
    always_ff @(posedge MCLK)
    begin
        if (TBL_WR_EN && int'(TBL_WR_ADDR) < RAM_DEPTH)
            shadow[TBL_WR_ADDR] <= TBL_WR_DATA;
        for (int i = 0; i < NUM_CHAN; i++)
            if (!RST_N)
                rank_m[i] <= CHAN_W'(i);
            else if (TBL_WR_EN && TBL_WR_ADDR == PRIO_ADDR
                     && TBL_WR_DATA[PRIO_CHAN_LSB +: CHAN_W] == CHAN_W'(i))
                rank_m[i] <= TBL_WR_DATA[PRIO_RANK_LSB +: CHAN_W];
    end
    always_comb
    begin
        low       = INDEX_NONE;
        best_rank = '1;
        for (int i = 0; i < NUM_CHAN; i++)
            if (act[i] && (low == INDEX_NONE || rank_m[i] < best_rank))
            begin
                low       = CHAN_W'(i + 1);
                best_rank = rank_m[i];
            end
    end
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    a_req_raise: assert property (|act |-> ##2 VEC_PORT_REQ)
        else $error("request not presented");
    a_no_forward: assert property (!(|act) |-> ##2 !VEC_PORT_REQ)
        else $error("disabled or reserved forwarded");
    a_lowest_wins: assert property (|act |-> ##2 IRQ_INDEX == $past(low, 2))
        else $error("wrong winner index");
    a_idle_index: assert property (!(|act) |-> ##2 IRQ_INDEX == INDEX_NONE)
        else $error("index not phantom");
    a_vec_same: assert property (VEC_PORT_ADDR == IRQ_VECTOR)
        else $error("vector outputs differ");
    a_parity_quiet: assert property (!VEC_PORT_REQ |-> !PARITY_ERR)
        else $error("parity flag while idle");
    a_usable_slot: assert property (VEC_PORT_REQ |-> IRQ_INDEX inside {[1:95]})
        else $error("index out of range");
    a_reset_clear: assert property (disable iff (1'b0) !RST_N |=> !VEC_PORT_REQ
        && IRQ_INDEX == INDEX_NONE && !PARITY_ERR)
        else $error("outputs not cleared");
    a_vector_table: assert property (VEC_PORT_REQ && !$past(TBL_WR_EN) |->
        VEC_PORT_ADDR == shadow[IRQ_INDEX])
        else $error("vector not from channel entry");
    c_win: cover property (|act ##2 VEC_PORT_REQ);
    c_top: cover property (VEC_PORT_REQ && IRQ_INDEX == 7'h01);
    c_far: cover property (VEC_PORT_REQ && IRQ_INDEX == 7'h59);
    c_rank: cover property (VEC_PORT_REQ && IRQ_INDEX == 7'h3E);
endmodule
bind vimgr_top vimgr_checker u_chk (.*);

// ===== verification/vimgr_periph.sv
`timescale 1ns/10ps
module vimgr_periph
    import vimgr_pkg::*;
(
    // Clock
    input  wire logic                MCLK,
    // Wanted levels and request lines
    input  wire logic [NUM_CHAN-1:0] want,
    output logic      [NUM_CHAN-1:0] req_out
);
    // Sources hold their level until told otherwise
    always_ff @(posedge MCLK)
        req_out <= want;
endmodule

// ===== verification/vimgr_top_tb.sv
`timescale 1ns/10ps
module vimgr_top_tb;
    import vimgr_pkg::*;
    logic                MCLK = 1'b0, RST_N = 1'b0, TBL_WR_EN = 1'b0;
    logic                VEC_PORT_REQ, PARITY_ERR;
    logic [NUM_CHAN-1:0] want = '0, CHAN_ENABLE = '0, REQ_IN;
    logic [CHAN_W-1:0]   TBL_WR_ADDR = '0, IRQ_INDEX;
    logic [VEC_W-1:0]    TBL_WR_DATA = '0, VEC_PORT_ADDR, IRQ_VECTOR, tbl [RAM_DEPTH];
    int                  miscompares = 0, checked = 0;
    always #5 MCLK = ~MCLK;
    vimgr_periph PERIPH (.MCLK(MCLK), .want(want), .req_out(REQ_IN));
    vimgr_top DUT (.*);
    task automatic chk(input string n, input logic [VEC_W-1:0] e, input logic [VEC_W-1:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input int a, input logic [VEC_W-1:0] d);
        @(posedge MCLK);
        TBL_WR_EN <= 1'b1;
        TBL_WR_ADDR <= CHAN_W'(a);
        TBL_WR_DATA <= d;
        if (a < RAM_DEPTH)
            tbl[a] = d;
        @(posedge MCLK);
        TBL_WR_EN <= 1'b0;
    endtask
    // Two cycles through the design plus one through the sources
    task automatic win(input logic [NUM_CHAN-1:0] w, input logic [NUM_CHAN-1:0] e, input int c);
        int x;
        x = (c < 0) ? 0 : c + 1;
        @(posedge MCLK);
        want <= w;
        CHAN_ENABLE <= e;
        repeat (4) @(posedge MCLK);
        #1;
        chk("req", 32'(c >= 0), 32'(VEC_PORT_REQ));
        chk("index", 32'(x), 32'(IRQ_INDEX));
        chk("vector", tbl[x], VEC_PORT_ADDR);
        chk("swvector", tbl[x], IRQ_VECTOR);
        chk("parity", 32'h0, 32'(PARITY_ERR));
    endtask
    // Rank word: channel in the low field, rank in the second byte
    task automatic s_rank();
        wr(int'(PRIO_ADDR), 32'h00007F00);
        wr(int'(PRIO_ADDR), 32'h0000003D);
        win('1, '1, 61);
        wr(int'(PRIO_ADDR), 32'h00000000);
        wr(int'(PRIO_ADDR), 32'h00003D3D);
        win('1, '1, 0);
    endtask
    task automatic s_map();
        for (int i = 0; i < NUM_CHAN; i++)
            win(96'h1 << i, 96'h1 << i, (USED_MASK[i] && i <= LAST_USABLE) ? i : -1);
    endtask
    task automatic s_block();
        win('1, '0, -1);
        win('1, 96'h1 << 85, 85);
        win('1, ~96'h1, 2);
    endtask
    task automatic s_order();
        win('1, '1, 0);
        win(~96'h1, '1, 2);
        win(96'h8000_0000_0000_0000_0000_0102, '1, -1);
    endtask
    task automatic s_rewrite();
        win(96'h4, 96'h4, 2);
        wr(3, 32'h5EED0003);
        win(96'h4, 96'h4, 2);
        win('0, 96'h4, -1);
    endtask
    task automatic report_and_stop();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #1000000;
        miscompares++;
        report_and_stop();
    end
    initial
    begin
        // Phantom entry loaded under reset, so the idle fetch never reads X
        repeat (8) @(posedge MCLK);
        wr(0, 32'hC35A0000);
        RST_N <= 1'b1;
        for (int a = 1; a < RAM_DEPTH; a++)
            wr(a, 32'hC35A0000 + 32'(a));
        s_map();
        s_block();
        s_order();
        s_rewrite();
        s_rank();
        report_and_stop();
    end
endmodule
